/* File: rtl/tdr_pkg.sv */
// Purpose: Shared constants and types for the two-wire debug register select block
// Assumes: 8-bit debug registers, one system clock and one debug link clock
// Notes:   All offsets, codes and reset values live here by name
package tdr_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int TDR_DW = 8;
   localparam int TDR_CNT_W = 3;

   // ************************************************************
   // Link instructions and command word
   // ************************************************************
   typedef enum logic [1:0] {
      TDR_OP_DATA_RD = 2'b00,
      TDR_OP_DATA_WR = 2'b01,
      TDR_OP_ADDR_RD = 2'b10,
      TDR_OP_ADDR_WR = 2'b11
   } tdr_op_t;

   typedef struct packed {
      tdr_op_t op;
      logic [TDR_DW-1:0] data;
   } tdr_cmd_t;

   typedef enum logic [2:0] {
      TDR_LS_IDLE = 3'b000,
      TDR_LS_INS = 3'b001,
      TDR_LS_DIN = 3'b010,
      TDR_LS_WAIT = 3'b011,
      TDR_LS_RDY = 3'b100,
      TDR_LS_DOUT = 3'b101
   } tdr_lstate_t;

   localparam logic [TDR_CNT_W-1:0] TDR_CNT_ZERO = 3'h0;
   localparam logic [TDR_CNT_W-1:0] TDR_CNT_ONE = 3'h1;
   localparam logic [TDR_CNT_W-1:0] TDR_INS_LAST = 3'h1;
   localparam logic [TDR_CNT_W-1:0] TDR_BYTE_LAST = 3'h7;

   // ************************************************************
   // Target select values and register reset values
   // ************************************************************
   localparam logic [7:0] TDR_SEL_PART_ID = 8'h00;
   localparam logic [7:0] TDR_SEL_REV_ID = 8'h01;
   localparam logic [7:0] TDR_SEL_FP_CTL = 8'h02;
   localparam logic [7:0] TDR_SEL_FP_DATA = 8'hB4;
   localparam logic [7:0] TDR_SEL_PART_ID_ALT = 8'hFD;
   localparam logic [7:0] TDR_SEL_RESET = 8'h00;
   localparam logic [7:0] TDR_FP_CTL_RESET = 8'h00;
   localparam logic [7:0] TDR_FP_DATA_RESET = 8'h00;
   localparam logic [7:0] TDR_BYTE_ZERO = 8'h00;

   // ************************************************************
   // On-chip special-function read address of the part identifier
   // ************************************************************
   localparam logic [7:0] TDR_SFR_PART_ID_ADDR = 8'hFD;
   localparam logic [3:0] TDR_SFR_DEBUG_PAGE = 4'hF;

   // ************************************************************
   // Flash programming unlock and command codes
   // ************************************************************
   localparam logic [7:0] TDR_FP_UNLOCK_FIRST = 8'h02;
   localparam logic [7:0] TDR_FP_UNLOCK_SECOND = 8'h01;
   localparam logic [7:0] TDR_FC_BLOCK_RD = 8'h06;
   localparam logic [7:0] TDR_FC_BLOCK_WR = 8'h07;
   localparam logic [7:0] TDR_FC_PAGE_ERASE = 8'h08;
   localparam logic [7:0] TDR_FC_DEV_ERASE = 8'h03;

   typedef enum logic [2:0] {
      TDR_FCMD_NONE = 3'b000,
      TDR_FCMD_BLOCK_RD = 3'b001,
      TDR_FCMD_BLOCK_WR = 3'b010,
      TDR_FCMD_PAGE_ERASE = 3'b011,
      TDR_FCMD_DEV_ERASE = 3'b100
   } tdr_fcmd_t;

   typedef struct packed {
      logic wr;
      logic [TDR_DW-1:0] data;
      tdr_fcmd_t cmd;
   } tdr_fp_out_t;

endpackage

/* File: rtl/tdr_sync.sv */
// Purpose: Two-flop synchroniser for levels and toggles
// Assumes: Input is a level or a slow toggle from another domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module tdr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   if (W < 1) begin : g_bad_width
      $error("tdr_sync width must be at least one");
   end

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;

endmodule
`default_nettype wire

/* File: rtl/tdr_link.sv */
// Purpose: Debug-link bit engine on the host's debug clock
// Assumes: Host changes the data pin on falling edges; we sample on rising
// Notes:   Frame is start bit, 2 instruction bits, optional byte, wait/ready, optional byte
`timescale 1ns/10ps
`default_nettype none
module tdr_link
   import tdr_pkg::*;
(
   // Link clock and reset
   input wire logic link_clk_i,
   input wire logic rst_b_i,
   // Data pin
   input wire logic data_i,
   output logic data_o,
   output logic data_oe_b_o,
   // Toward system domain
   output logic req_tgl_o,
   output tdr_cmd_t cmd_o,
   input wire logic ack_tgl_i,
   input wire logic [TDR_DW-1:0] rdata_i
);

   tdr_lstate_t state_reg, state_next;
   logic [TDR_CNT_W-1:0] cnt_reg, cnt_next;
   logic [TDR_DW-1:0] shift_reg, shift_next;
   tdr_op_t op_reg, op_next;
   logic req_reg, req_next;
   logic dout_reg, dout_next;
   logic oe_b_reg, oe_b_next;
   logic [1:0] ins_w;
   logic done_w;

   assign ins_w = {op_reg[0], data_i};
   assign done_w = (ack_tgl_i == req_reg);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      op_next = op_reg;
      req_next = req_reg;
      dout_next = dout_reg;
      oe_b_next = oe_b_reg;
      case (state_reg)
         TDR_LS_IDLE: begin
            oe_b_next = 1'b1;
            dout_next = 1'b0;
            if (data_i) begin
               state_next = TDR_LS_INS;
               cnt_next = TDR_CNT_ZERO;
            end
         end
         TDR_LS_INS: begin
            op_next = tdr_op_t'(ins_w);
            cnt_next = cnt_reg + TDR_CNT_ONE;
            if (cnt_reg == TDR_INS_LAST) begin
               cnt_next = TDR_CNT_ZERO;
               if (ins_w[0]) begin
                  state_next = TDR_LS_DIN;
               end else begin
                  req_next = ~req_reg;
                  state_next = TDR_LS_WAIT;
               end
            end
         end
         TDR_LS_DIN: begin
            shift_next = {data_i, shift_reg[TDR_DW-1:1]};
            cnt_next = cnt_reg + TDR_CNT_ONE;
            if (cnt_reg == TDR_BYTE_LAST) begin
               req_next = ~req_reg;
               state_next = TDR_LS_WAIT;
            end
         end
         // Device drives the shared data pin
         TDR_LS_WAIT: begin
            oe_b_next = 1'b0;
            dout_next = done_w;
            if (done_w) begin
               state_next = TDR_LS_RDY;
            end
         end
         TDR_LS_RDY: begin
            if (!op_reg[0]) begin
               shift_next = rdata_i;
               dout_next = rdata_i[0];
               cnt_next = TDR_CNT_ZERO;
               state_next = TDR_LS_DOUT;
            end else begin
               oe_b_next = 1'b1;
               dout_next = 1'b0;
               state_next = TDR_LS_IDLE;
            end
         end
         TDR_LS_DOUT: begin
            if (cnt_reg == TDR_BYTE_LAST) begin
               oe_b_next = 1'b1;
               dout_next = 1'b0;
               state_next = TDR_LS_IDLE;
            end else begin
               dout_next = shift_reg[1];
               shift_next = {1'b0, shift_reg[TDR_DW-1:1]};
               cnt_next = cnt_reg + TDR_CNT_ONE;
            end
         end
         default: begin
            oe_b_next = 1'b1;
            dout_next = 1'b0;
            state_next = TDR_LS_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= TDR_LS_IDLE;
         cnt_reg <= TDR_CNT_ZERO;
         shift_reg <= TDR_BYTE_ZERO;
         op_reg <= TDR_OP_DATA_RD;
         req_reg <= 1'b0;
         dout_reg <= 1'b0;
         oe_b_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         op_reg <= op_next;
         req_reg <= req_next;
         dout_reg <= dout_next;
         oe_b_reg <= oe_b_next;
      end
   end

   assign data_o = dout_reg;
   assign data_oe_b_o = oe_b_reg;
   assign req_tgl_o = req_reg;
   assign cmd_o = '{op: op_reg, data: shift_reg};

endmodule
`default_nettype wire

/* File: rtl/tdr_top.sv */
// Purpose: Device-side debug register select behind the two-wire debug link
// Assumes: Debug clock stands still between frames; data pin is synchronous to it
// Notes:   Commands cross to clk_i by toggle handshake; debug registers live on clk_i, the link engine on the debug clock
`timescale 1ns/10ps
`default_nettype none

// Function
// - Host supplies debug clock; data travels both ways on one shared pin.
// - Debug registers are reachable through the debug link commands; part id also by software read, flash data also by core load.
// - Eight-bit target select, host-written, steers later data read and write.
// - Select 0x00 makes data reads return the part identifier.
// - Select 0x01 makes data reads return the revision identifier.
// - Select 0x02 makes data reads and writes reach flash programming control.
// - Select 0xB4 makes data reads and writes reach flash programming data.
// - Part identifier is read-only, eight bits, fixed family value.
// - Part identifier also at debug address 0xFD and software address 0xFD page 0xF.
// - Revision identifier is read-only, eight bits, zero means first revision.
// - Writing 0x02 then 0x01 to control enables programming until system reset.
// - Data register carries commands 0x06, 0x07, 0x08, 0x03 plus addresses and data.
module tdr_top
   import tdr_pkg::*;
#(
   // Part identifier default is arbitrary; set it per product
   parameter logic [TDR_DW-1:0] PART_ID = 8'h5A,
   parameter logic [TDR_DW-1:0] REV_ID = 8'h00
) (
   // System clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Debug link pins
   input wire logic debug_clock_pin_i,
   input wire logic debug_data_pin_i,
   output logic debug_data_pin_o,
   output logic debug_data_pin_oe_b_o,
   // On-chip special-function read port
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [3:0] sfr_page_i,
   output logic [TDR_DW-1:0] sfr_rdata_o,
   output logic sfr_rvalid_o,
   // Flash programming side
   input wire logic fp_load_i,
   input wire logic [TDR_DW-1:0] fp_load_data_i,
   output logic fp_prog_en_o,
   output logic [TDR_DW-1:0] fp_ctl_o,
   output logic fp_wr_o,
   output logic [TDR_DW-1:0] fp_wdata_o,
   output tdr_fcmd_t fp_cmd_o
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_b;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_b = rst_sync_reg;

   // ************************************************************
   // Link domain and crossings
   // ************************************************************
   logic link_req_tgl;
   tdr_cmd_t link_cmd;
   logic link_ack_sync;
   logic sys_req_sync;
   logic ack_tgl_reg;
   logic req_seen_reg;
   logic [TDR_DW-1:0] rdata_reg;
   logic link_dout;
   logic link_oe_b;

   // Link engine shares the system reset; the debug clock is idle at release
   tdr_link u_link (
      .link_clk_i(debug_clock_pin_i),
      .rst_b_i(rst_b),
      .data_i(debug_data_pin_i),
      .data_o(link_dout),
      .data_oe_b_o(link_oe_b),
      .req_tgl_o(link_req_tgl),
      .cmd_o(link_cmd),
      .ack_tgl_i(link_ack_sync),
      .rdata_i(rdata_reg)
   );

   tdr_sync #(.W(1)) u_ack_sync (
      .clk_i(debug_clock_pin_i),
      .rst_b_i(rst_b),
      .d_i(ack_tgl_reg),
      .q_o(link_ack_sync)
   );

   tdr_sync #(.W(1)) u_req_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b),
      .d_i(link_req_tgl),
      .q_o(sys_req_sync)
   );

   // Pin drivers are flops inside the link engine
   assign debug_data_pin_o = link_dout;
   assign debug_data_pin_oe_b_o = link_oe_b;

   // ************************************************************
   // Command decode
   // ************************************************************
   logic [TDR_DW-1:0] sel_reg;
   logic [TDR_DW-1:0] fp_ctl_reg;
   logic [TDR_DW-1:0] fp_data_reg;
   logic armed_reg;
   logic prog_en_reg;
   logic new_cmd_w;
   logic data_wr_w;
   logic addr_wr_w;
   logic sel_part_w;
   logic sel_rev_w;
   logic sel_ctl_w;
   logic sel_dat_w;
   logic ctl_wr_w;
   logic dat_wr_w;
   logic [TDR_DW-1:0] data_rd_w;
   logic [TDR_DW-1:0] rd_value_w;
   tdr_fcmd_t fcmd_w;

   // Command word is stable while the request toggle is pending
   assign new_cmd_w = sys_req_sync ^ req_seen_reg;
   assign data_wr_w = new_cmd_w && (link_cmd.op == TDR_OP_DATA_WR);
   assign addr_wr_w = new_cmd_w && (link_cmd.op == TDR_OP_ADDR_WR);

   // Debug address 0xFD also selects part id
   assign sel_part_w = (sel_reg == TDR_SEL_PART_ID) || (sel_reg == TDR_SEL_PART_ID_ALT);
   assign sel_rev_w = (sel_reg == TDR_SEL_REV_ID);
   assign sel_ctl_w = (sel_reg == TDR_SEL_FP_CTL);
   assign sel_dat_w = (sel_reg == TDR_SEL_FP_DATA);

   assign ctl_wr_w = data_wr_w && sel_ctl_w;
   assign dat_wr_w = data_wr_w && sel_dat_w;

   assign data_rd_w = sel_part_w ? PART_ID :
                      sel_rev_w ? REV_ID :
                      sel_ctl_w ? fp_ctl_reg :
                      sel_dat_w ? fp_data_reg : TDR_BYTE_ZERO;

   assign rd_value_w = (link_cmd.op == TDR_OP_ADDR_RD) ? sel_reg : data_rd_w;

   assign fcmd_w = (link_cmd.data == TDR_FC_BLOCK_RD) ? TDR_FCMD_BLOCK_RD :
                   (link_cmd.data == TDR_FC_BLOCK_WR) ? TDR_FCMD_BLOCK_WR :
                   (link_cmd.data == TDR_FC_PAGE_ERASE) ? TDR_FCMD_PAGE_ERASE :
                   (link_cmd.data == TDR_FC_DEV_ERASE) ? TDR_FCMD_DEV_ERASE :
                   TDR_FCMD_NONE;

   // ************************************************************
   // Handshake and read data
   // ************************************************************
   // Read data settles on the same edge as the acknowledge toggle
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         req_seen_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         rdata_reg <= TDR_BYTE_ZERO;
      end else if (new_cmd_w) begin
         req_seen_reg <= sys_req_sync;
         ack_tgl_reg <= ~ack_tgl_reg;
         rdata_reg <= rd_value_w;
      end
   end

   // ************************************************************
   // Target select register
   // ************************************************************
   // Select written by address write
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         sel_reg <= TDR_SEL_RESET;
      end else if (addr_wr_w) begin
         sel_reg <= link_cmd.data;
      end
   end

   // ************************************************************
   // Flash programming control and unlock
   // ************************************************************
   // Unlock sequence, sticky until reset
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         fp_ctl_reg <= TDR_FP_CTL_RESET;
         armed_reg <= 1'b0;
         prog_en_reg <= 1'b0;
      end else if (ctl_wr_w) begin
         fp_ctl_reg <= link_cmd.data;
         armed_reg <= (link_cmd.data == TDR_FP_UNLOCK_FIRST);
         if (armed_reg && (link_cmd.data == TDR_FP_UNLOCK_SECOND)) begin
            prog_en_reg <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Flash programming data
   // ************************************************************
   // Host write beats a core load in the same cycle; the core can retry
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         fp_data_reg <= TDR_FP_DATA_RESET;
      end else if (dat_wr_w) begin
         fp_data_reg <= link_cmd.data;
      end else if (fp_load_i) begin
         fp_data_reg <= fp_load_data_i;
      end
   end

   // Byte handed to flash only once unlocked
   tdr_fp_out_t fp_out_reg;
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         fp_out_reg <= '{wr: 1'b0, data: TDR_BYTE_ZERO, cmd: TDR_FCMD_NONE};
      end else begin
         fp_out_reg.wr <= dat_wr_w && prog_en_reg;
         if (dat_wr_w && prog_en_reg) begin
            fp_out_reg.data <= link_cmd.data;
            fp_out_reg.cmd <= fcmd_w;
         end
      end
   end

   // ************************************************************
   // Special-function read of the part identifier
   // ************************************************************
   logic sfr_hit_w;
   logic [TDR_DW-1:0] sfr_rdata_reg;
   logic sfr_rvalid_reg;

   // Software read at 0xFD, page 0xF
   assign sfr_hit_w = (sfr_addr_i == TDR_SFR_PART_ID_ADDR) && (sfr_page_i == TDR_SFR_DEBUG_PAGE);

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata_reg <= TDR_BYTE_ZERO;
         sfr_rvalid_reg <= 1'b0;
      end else begin
         sfr_rvalid_reg <= sfr_rd_i;
         sfr_rdata_reg <= (sfr_rd_i && sfr_hit_w) ? PART_ID : TDR_BYTE_ZERO;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign sfr_rdata_o = sfr_rdata_reg;
   assign sfr_rvalid_o = sfr_rvalid_reg;
   assign fp_prog_en_o = prog_en_reg;
   assign fp_ctl_o = fp_ctl_reg;
   assign fp_wr_o = fp_out_reg.wr;
   assign fp_wdata_o = fp_out_reg.data;
   assign fp_cmd_o = fp_out_reg.cmd;

endmodule
`default_nettype wire

/* File: tb/tdr_host_model.sv */
// Purpose: Host adapter model that clocks the debug link and shares the data pin
// Assumes: Device drives the pin only while its enable is low
// Notes: Clock stands still low between frames; a released pin shows the inverse level
`timescale 1ns/10ps
`default_nettype none
module tdr_host_model
   import tdr_pkg::*;
(
   // Link pins
   output logic dclk_o,
   output logic dpin_o,
   input wire logic dev_d_i,
   input wire logic dev_oe_b_i
);
   logic hd = 1'b0;
   logic hen = 1'b1;
   logic last = 1'b0;
   assign dpin_o = !dev_oe_b_i ? dev_d_i : (hen ? hd : ~last);
   always @(dpin_o) if (hen || !dev_oe_b_i) last = dpin_o;
   initial dclk_o = 1'b0;
   task automatic pulse();
      #24 dclk_o = 1'b1;
      #24 dclk_o = 1'b0;
   endtask
   task automatic bit_out(input logic b);
      hd = b;
      pulse();
   endtask
   task automatic xfer(input tdr_op_t op, input logic [7:0] wd,
                       output logic [7:0] rd, output logic ok);
      int n;
      rd = 8'h00;
      bit_out(1'b1);
      bit_out(op[1]);
      bit_out(op[0]);
      if (op[0]) for (int i = 0; i < 8; i++) bit_out(wd[i]);
      hen = 1'b0;
      n = 0;
      // Bounded wait for the ready bit
      do begin
         pulse();
         n++;
      end while (!(dev_oe_b_i === 1'b0 && dpin_o === 1'b1) && n < 16);
      ok = (n < 16);
      if (!op[0]) for (int i = 0; i < 8; i++) begin
         pulse();
         rd[i] = dpin_o;
      end
      pulse();
      ok = ok && (dev_oe_b_i === 1'b1);
      hd = 1'b0;
      hen = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: tb/tdr_top_assertions.sv */
// Purpose: Port-level checker for the debug register select block
// Assumes: Sees only the top module's ports
// Notes: Bound into every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module tdr_top_assertions
   import tdr_pkg::*;
#(
   parameter logic [TDR_DW-1:0] PART_ID = 8'h5A
) (
   // Clocks and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic debug_clock_pin_i,
   // Watched ports
   input wire logic debug_data_pin_o,
   input wire logic debug_data_pin_oe_b_o,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [3:0] sfr_page_i,
   input wire logic [TDR_DW-1:0] sfr_rdata_o,
   input wire logic sfr_rvalid_o,
   input wire logic fp_prog_en_o,
   input wire logic [TDR_DW-1:0] fp_ctl_o,
   input wire logic fp_wr_o,
   input wire logic [TDR_DW-1:0] fp_wdata_o,
   input wire tdr_fcmd_t fp_cmd_o
);
   wire id_hit = (sfr_addr_i == TDR_SFR_PART_ID_ADDR) && (sfr_page_i == TDR_SFR_DEBUG_PAGE);
   tdr_fcmd_t exp_cmd;
   assign exp_cmd = (fp_wdata_o == TDR_FC_BLOCK_RD) ? TDR_FCMD_BLOCK_RD :
                    (fp_wdata_o == TDR_FC_BLOCK_WR) ? TDR_FCMD_BLOCK_WR :
                    (fp_wdata_o == TDR_FC_PAGE_ERASE) ? TDR_FCMD_PAGE_ERASE :
                    (fp_wdata_o == TDR_FC_DEV_ERASE) ? TDR_FCMD_DEV_ERASE : TDR_FCMD_NONE;
   sequence s_id_req;
      sfr_rd_i && id_hit;
   endsequence
   sequence s_turn;
      $fell(debug_data_pin_oe_b_o);
   endsequence
   a_sfr_read_lat: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sfr_rd_i |=> sfr_rvalid_o) else $error("read answer missing");
   a_sfr_no_spur: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !sfr_rd_i |=> !sfr_rvalid_o) else $error("read answer without request");
   a_sfr_part_id: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_id_req |=> sfr_rdata_o == PART_ID) else $error("wrong part identifier");
   a_sfr_other_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sfr_rd_i && !id_hit |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
   a_prog_en_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      fp_prog_en_o |=> fp_prog_en_o) else $error("programming enable dropped");
   a_prog_en_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(fp_prog_en_o) |-> ##[0:2] (fp_ctl_o == TDR_FP_UNLOCK_SECOND))
      else $error("enable without unlock write");
   a_wr_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      fp_wr_o |=> !fp_wr_o) else $error("flash write pulse too long");
   a_wr_needs_en: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      fp_wr_o |-> fp_prog_en_o) else $error("flash write while locked");
   a_cmd_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      fp_wr_o |-> fp_cmd_o == exp_cmd) else $error("flash command decode wrong");
   a_turn_wait_low: assert property (@(posedge debug_clock_pin_i) disable iff (!rst_b_i)
      s_turn |-> !debug_data_pin_o) else $error("first driven bit not a wait");
endmodule
bind tdr_top tdr_top_assertions #(.PART_ID(PART_ID)) tdr_top_assertions_inst (
   .clk_i, .rst_b_i, .debug_clock_pin_i, .debug_data_pin_o, .debug_data_pin_oe_b_o,
   .sfr_rd_i, .sfr_addr_i, .sfr_page_i, .sfr_rdata_o, .sfr_rvalid_o, .fp_prog_en_o,
   .fp_ctl_o, .fp_wr_o, .fp_wdata_o, .fp_cmd_o
);
`default_nettype wire

/* File: tb/two_wire_debug_register_select_tb_top.sv */
// Purpose: Self-checking bench for the debug register select block
// Assumes: Host model drives the link; bench drives the on-chip ports
// Notes: Flash and read-port results are matched against queued notes
`timescale 1ns/10ps
`default_nettype none
module two_wire_debug_register_select_tb_top
   import tdr_pkg::*;
;
   // Arbitrary part identifier value
   localparam logic [7:0] PID = 8'h3C;
   localparam logic [7:0] FC [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
   localparam tdr_fcmd_t FK [4] = '{TDR_FCMD_BLOCK_RD, TDR_FCMD_BLOCK_WR,
                                     TDR_FCMD_PAGE_ERASE, TDR_FCMD_DEV_ERASE};
   logic clk_i, rst_b_i, dclk, dpin, dout, doe_b;
   logic sfr_rd_i, sfr_rvalid_o, fp_load_i, fp_prog_en_o, fp_wr_o;
   logic [7:0] sfr_addr_i, sfr_rdata_o, fp_load_data_i, fp_ctl_o, fp_wdata_o;
   logic [3:0] sfr_page_i;
   tdr_fcmd_t fp_cmd_o;
   logic [10:0] fpq[$];
   logic [10:0] fe;
   logic [7:0] sfq[$];
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 48;
   tdr_top #(.PART_ID(PID), .REV_ID(8'h00)) tdr_top_inst (
      .clk_i, .rst_b_i, .debug_clock_pin_i(dclk), .debug_data_pin_i(dpin),
      .debug_data_pin_o(dout), .debug_data_pin_oe_b_o(doe_b), .sfr_rd_i, .sfr_addr_i,
      .sfr_page_i, .sfr_rdata_o, .sfr_rvalid_o, .fp_load_i, .fp_load_data_i,
      .fp_prog_en_o, .fp_ctl_o, .fp_wr_o, .fp_wdata_o, .fp_cmd_o
   );
   tdr_host_model tdr_host_model_inst (
      .dclk_o(dclk), .dpin_o(dpin), .dev_d_i(dout), .dev_oe_b_i(doe_b)
   );
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic lk(input tdr_op_t op, input logic [7:0] wd, output logic [7:0] rd);
      logic ok;
      tdr_host_model_inst.xfer(op, wd, rd, ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] sel, input logic [7:0] d);
      logic [7:0] r;
      lk(TDR_OP_ADDR_WR, sel, r);
      lk(TDR_OP_DATA_WR, d, r);
   endtask
   task automatic rd_chk(input logic [7:0] sel, input logic [7:0] exp);
      logic [7:0] r;
      lk(TDR_OP_ADDR_WR, sel, r);
      lk(TDR_OP_DATA_RD, 8'h00, r);
      check(r, exp);
   endtask
   task automatic do_reset();
      rst_b_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // Watchers take the oldest note whenever a result appears
   always @(negedge clk_i) if (fp_wr_o === 1'b1) begin
      fe = (fpq.size() > 0) ? fpq.pop_front() : 11'h7FF;
      check(fp_wdata_o, fe[10:3]);
      check({5'h00, fp_cmd_o}, {5'h00, fe[2:0]});
   end
   always @(negedge clk_i) if (sfr_rvalid_o === 1'b1) begin
      check(sfr_rdata_o, (sfq.size() > 0) ? sfq.pop_front() : 8'hEE);
   end
   initial begin
      #1000000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      logic [7:0] r, v;
      rst_b_i = 1'b0;
      {sfr_rd_i, fp_load_i} = 2'b00;
      {sfr_addr_i, fp_load_data_i} = 16'h0000;
      sfr_page_i = 4'h0;
      do_reset();
      lk(TDR_OP_ADDR_RD, 8'h00, r);
      check(r, TDR_SEL_RESET);
      rd_chk(TDR_SEL_PART_ID, PID);
      rd_chk(TDR_SEL_REV_ID, 8'h00);
      v = 8'($random(seed));
      wr(TDR_SEL_PART_ID, v);
      wr(TDR_SEL_REV_ID, ~v);
      rd_chk(TDR_SEL_PART_ID, PID);
      rd_chk(TDR_SEL_REV_ID, 8'h00);
      rd_chk(TDR_SEL_PART_ID_ALT, PID);
      rd_chk(8'h55, 8'h00);
      lk(TDR_OP_ADDR_RD, 8'h00, r);
      check(r, 8'h55);
      wr(TDR_SEL_FP_CTL, v);
      rd_chk(TDR_SEL_FP_CTL, v);
      check(fp_ctl_o, v);
      // A stray write between the unlock codes must disarm
      wr(TDR_SEL_FP_CTL, 8'h02);
      wr(TDR_SEL_FP_CTL, 8'h05);
      wr(TDR_SEL_FP_CTL, 8'h01);
      wr(TDR_SEL_FP_DATA, 8'h07);
      check({7'h00, fp_prog_en_o}, 8'h00);
      rd_chk(TDR_SEL_FP_DATA, 8'h07);
      wr(TDR_SEL_FP_CTL, TDR_FP_UNLOCK_FIRST);
      wr(TDR_SEL_FP_CTL, TDR_FP_UNLOCK_SECOND);
      check({7'h00, fp_prog_en_o}, 8'h01);
      // every command code, then a plain data byte
      for (int i = 0; i < 5; i++) begin
         v = (i < 4) ? FC[i] : (8'h80 | 8'($random(seed)));
         fpq.push_back({v, (i < 4) ? FK[i] : TDR_FCMD_NONE});
         wr(TDR_SEL_FP_DATA, v);
      end
      rd_chk(TDR_SEL_FP_DATA, v);
      v = 8'($random(seed));
      @(posedge clk_i);
      #1 fp_load_i = 1'b1;
      fp_load_data_i = v;
      @(posedge clk_i);
      #1 fp_load_i = 1'b0;
      rd_chk(TDR_SEL_FP_DATA, v);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         #1 sfr_rd_i = 1'b1;
         sfr_addr_i = (i < 2) ? TDR_SFR_PART_ID_ADDR : 8'($random(seed));
         sfr_page_i = i[0] ? 4'h0 : TDR_SFR_DEBUG_PAGE;
         sfq.push_back((sfr_addr_i == 8'hFD && sfr_page_i == 4'hF) ? PID : 8'h00);
      end
      @(posedge clk_i);
      #1 sfr_rd_i = 1'b0;
      // Let the last read answer stand before reset wipes it
      @(posedge clk_i);
      #1 do_reset();
      check({7'h00, fp_prog_en_o}, 8'h00);
      rd_chk(TDR_SEL_FP_CTL, TDR_FP_CTL_RESET);
      lk(TDR_OP_ADDR_RD, 8'h00, r);
      check(r, TDR_SEL_FP_CTL);
      repeat (5) @(posedge clk_i);
      check(8'(fpq.size() + sfq.size()), 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
